// ==== verification/aosm_host_model.sv ====
// Host controller model: holds the command levels a host would write over I2C.
// Assumes the bench calls put(); every change lands at a falling edge of i_mclk.
`timescale 1ns/100ps
module aosm_host_model (
    input wire logic i_mclk,
    input wire logic i_out_phase,
    output logic o_pwm_on,
    output logic o_play,
    output logic o_dc_diag,
    output logic o_prog
);
    logic slow_slope_r = 1'b0;
    initial {o_pwm_on, o_play, o_dc_diag, o_prog} = 4'h0;
    // Out-of-phase modulation always gets the slow output slope, or edges ring.
    always @(negedge i_mclk) slow_slope_r <= i_out_phase;
    // Writes one command set: {pwm_on, play, dc_diag, prog_change}.
    task automatic put(input logic [3:0] c);
        @(negedge i_mclk);
        {o_pwm_on, o_play, o_dc_diag, o_prog} = c;
    endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the amplifier operating state machine.
// Assumes short counts: FAULT_CYC 20, PWM_CYC 5, DEB 4.
`timescale 1ns/100ps
module testbench;
    localparam int FC = 20;
    localparam int PC = 5;
    localparam aosm_pkg::aosm_state_e SB = aosm_pkg::AOSM_STANDBY;
    localparam aosm_pkg::aosm_state_e DG = aosm_pkg::AOSM_DIAG;
    localparam aosm_pkg::aosm_state_e ID = aosm_pkg::AOSM_IDLE;
    localparam aosm_pkg::aosm_state_e MU = aosm_pkg::AOSM_MUTE;
    localparam aosm_pkg::aosm_state_e PL = aosm_pkg::AOSM_PLAY;
    localparam aosm_pkg::aosm_state_e DC = aosm_pkg::AOSM_DCDIAG;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic [3:0] sel = 4'h0;
    logic pll = 1'b1;
    logic i2s = 1'b1;
    logic srst = 1'b0;
    logic ov = 1'b0;
    logic [3:0] am = 4'h0;
    logic [1:0] ramp = 2'h0;
    aosm_pkg::aosm_fault_s flt = '0;
    aosm_pkg::aosm_state_e o_state;
    aosm_pkg::aosm_state_e prev_st = aosm_pkg::AOSM_STANDBY;
    aosm_pkg::aosm_state_e exp_q[$];
    logic [6:0] o_addr, a;
    logic o_en, o_leg, o_lv, o_op, o_sup, o_bias, o_ld, o_pwm, o_play, o_flt, o_i2s;
    logic [1:0] o_ramp;
    logic c_pwm, c_play, c_dc, c_prog;
    logic v, lg, lv, op;
    logic [3:0] apat [8] = '{4'h4, 4'hC, 4'h2, 4'h6, 4'h5, 4'hD, 4'h3, 4'h7};
    logic [3:0] lpat [4] = '{4'hE, 4'hF, 4'h8, 4'h9};
    int fail_count = 0;
    int check_count = 0;
    int seed = 94;
    bit watch = 1'b1;

    // Clock of 40 ns.
    always #20 i_mclk = ~i_mclk;

    aosm_host_model u_aosm_host_model (.i_mclk(i_mclk), .i_out_phase(o_op),
        .o_pwm_on(c_pwm), .o_play(c_play), .o_dc_diag(c_dc), .o_prog(c_prog));

    aosm_core #(.FAULT_CYC(FC), .PWM_CYC(PC), .DEB(4)) u_aosm_core (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_select_pin(sel), .i_pll_locked(pll),
        .i_i2s_valid(i2s), .i_supply_reset(srst), .i_fault(flt),
        .i_overvolt_shutdown(ov), .i_low_batt(am[3]), .i_high_batt(am[2]),
        .i_thermal_mute(am[1]), .i_hardware_mute_input(~am[0]), .i_cmd_pwm_on(c_pwm),
        .i_cmd_play(c_play), .i_cmd_dc_diag(c_dc), .i_cmd_prog_change(c_prog),
        .i_ramp_sel(ramp), .o_state(o_state), .o_i2c_target_addr(o_addr),
        .o_i2c_target_en(o_en), .o_legacy(o_leg), .o_low_voltage(o_lv),
        .o_out_phase(o_op), .o_supplies_on(o_sup), .o_bias_mid(o_bias),
        .o_load_defaults(o_ld), .o_pwm_on(o_pwm), .o_play(o_play), .o_ramp_sel(o_ramp),
        .o_fault_reported(o_flt), .o_i2s_enable(o_i2s));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    // Waits, with a bound, until every announced state change has been seen.
    task automatic settle(input int n);
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < n) begin
            @(negedge i_mclk);
            k++;
        end
        chk("pending", exp_q.size(), 0);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Each state change takes the oldest note; an unannounced change is caught too.
    always @(posedge i_mclk) begin
        if (i_rstn && watch && o_state !== prev_st) begin
            if (exp_q.size() == 0)
                chk("state_extra", o_state, prev_st);
            else
                chk("state", o_state, exp_q.pop_front());
        end
        prev_st <= o_state;
    end

    // Bound on the whole run, several times what the tests need.
    initial begin
        #(40 * 4000);
        fail_count++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: decode table, then one full walk through the states.
    initial begin
        cyc(5);
        chk("rst_state", o_state, SB);
        chk("rst_dflt", o_ld, 1);
        i_rstn = 1'b1;
        cyc(2);
        sel = 4'h4;
        cyc(2);
        sel = 4'h0;
        cyc(12);
        chk("glitch", o_state, SB);
        for (int p = 0; p < 16; p++) begin
            {v, lg, lv, op, a} = '0;
            for (int i = 0; i < 8; i++) if (apat[i] == p) {v, a} = {1'b1, 7'h70 + 7'(i)};
            for (int i = 0; i < 4; i++) if (lpat[i] == p) {v, lg, lv, op} = {3'h7, i[0]};
            if (lg) lv = (p > 9);
            sel = p[3:0];
            if (v) exp_q.push_back(DG);
            cyc(12);
            chk("sel_state", o_state, v ? DG : SB);
            chk("supplies", o_sup, v);
            chk("bias", o_bias, v);
            chk("dflt", o_ld, !v);
            chk("i2c_en", o_en, v & ~lg);
            if (v & ~lg) chk("addr", o_addr, a);
            chk("legacy", o_leg, lg);
            if (lg) chk("mode", {o_lv, o_op}, {lv, op});
            sel = 4'h0;
            if (v) exp_q.push_back(SB);
            cyc(12);
            settle(1);
        end
        $display("test decode done");
        flt[5 - ($unsigned($random(seed)) % 4)] = 1'b1;
        sel = 4'h4;
        exp_q.push_back(DG);
        cyc(12);
        chk("flt_early", o_flt, 0);
        cyc(FC + 8);
        chk("flt_rep", o_flt, 1);
        chk("pwm_diag", o_pwm, 0);
        flt = '0;
        exp_q.push_back(ID);
        cyc(FC - 4);
        chk("st_wait", o_state, DG);
        settle(10);
        chk("pwm_idle", o_pwm, 0);
        chk("i2s_on", o_i2s, 1);
        u_aosm_host_model.put(4'h4);
        cyc(5);
        exp_q.push_back(MU);
        u_aosm_host_model.put(4'h8);
        settle(5);
        u_aosm_host_model.put(4'h0);
        cyc(PC + 3);
        chk("pwm_mute", o_pwm, 1);
        ramp = 2'($random(seed));
        cyc(3);
        chk("ramp", o_ramp, ramp);
        exp_q.push_back(PL);
        u_aosm_host_model.put(4'h4);
        settle(5);
        chk("play", o_play, 1);
        $display("test walk done");
        for (int k = 0; k < 4; k++) begin
            exp_q.push_back(MU);
            am = 4'h1 << k;
            settle(8);
            chk("amute", o_play, 0);
            exp_q.push_back(PL);
            am = 4'h0;
            settle(8);
        end
        exp_q.push_back(MU);
        am = 4'h1;
        settle(8);
        u_aosm_host_model.put(4'h5);
        u_aosm_host_model.put(4'h4);
        am = 4'h0;
        cyc(10);
        chk("no_return", o_state, MU);
        exp_q.push_back(PL);
        u_aosm_host_model.put(4'h0);
        u_aosm_host_model.put(4'h4);
        settle(5);
        exp_q.push_back(MU);
        u_aosm_host_model.put(4'h0);
        settle(5);
        exp_q.push_back(DC);
        u_aosm_host_model.put(4'h2);
        settle(5);
        exp_q.push_back(MU);
        u_aosm_host_model.put(4'h0);
        settle(5);
        $display("test mute done");
        exp_q.push_back(PL);
        u_aosm_host_model.put(4'h4);
        settle(5);
        exp_q.push_back(DG);
        flt.overcurrent = 1'b1;
        settle(5);
        chk("pwm_trip", o_pwm, 0);
        watch = 1'b0;
        flt = '0;
        ov = 1'b1;
        cyc(6);
        chk("i2s_off", o_i2s, 0);
        ov = 1'b0;
        pll = 1'b0;
        cyc(8);
        chk("pll_loss", o_state, SB);
        chk("sup_off", o_sup, 0);
        pll = 1'b1;
        cyc(4);
        chk("pll_back", o_sup, 1);
        i2s = 1'b0;
        cyc(4);
        chk("i2s_loss", o_state, SB);
        i2s = 1'b1;
        cyc(4);
        srst = 1'b1;
        cyc(4);
        chk("sup_rst", o_state, SB);
        $display("test protect done");
        // Legacy pattern with no host commands must walk all the way to play by itself.
        u_aosm_host_model.put(4'h0);
        watch = 1'b1;
        exp_q.push_back(DG);
        exp_q.push_back(ID);
        exp_q.push_back(MU);
        exp_q.push_back(PL);
        srst = 1'b0;
        sel = 4'hE;
        settle(FC + 20);
        chk("legacy_play", o_play, 1);
        $display("test legacy done");
        test_done();
    end
endmodule

// ==== verilog/aosm_core.sv ====
// Operating state machine of a single-channel digital-input audio amplifier.
// Assumes host I2C commands arrive decoded as levels on the i_cmd_* ports, in the same clock.
// Notes on behaviour
// R1 - All select pins low keeps the device in standby with outputs grounded.
// R2 - Patterns 0100,1100,0010,0110 give addresses 1110000 to 1110011.
// R3 - Patterns 0101,1101,0011,0111 give addresses 1110100 to 1110111.
// R4 - Patterns 1110,1111,1000,1001 pick the four legacy modes without I2C.
// R5 - A valid pattern enables supplies, biases outputs mid-rail, loads register defaults.
// R6 - Standby pattern, PLL unlock, bad I2S or supply reset resets the amplifier.
// R7 - The device is only an I2C target, never a controller.
// R8 - Leaving standby enters the diagnostic state checking shorts, undervoltage, thermal.
// R9 - Diagnostic advances to idle only after faults absent 90 ms continuously.
// R10 - A persisting fault is reported after 90 ms; stay in diagnostic.
// R11 - Diagnostic accepts commands but keeps PWM switching off.
// R12 - Overcurrent, undervoltage, load dump or thermal shutdown forces diagnostic.
// R13 - Idle accepts commands while output switching stays disabled.
// R14 - PWM-on command moves idle to mute; switching starts within about 1 ms.
// R15 - Play bit set moves mute to play; cleared returns play to mute.
// R16 - Mute and play transition time is selectable by a host setting.
// R17 - Low battery, high battery, thermal or hardware mute force mute.
// R18 - Clearing all auto mutes returns to play if programming still requests it.
// R19 - DC diagnostic may be entered from mute only, on host request.
// R20 - Overvoltage shutdown turns off the audio input and floats its pins.
// R21 - Host sets the slow slope bit whenever out-of-phase modulation is chosen.
// R22 - Hardware mute input low mutes, high plays; it floats to play.
// R23 - Unlisted select patterns are treated as standby.
// R24 - Select pins are synchronised and debounced before being acted upon.
`timescale 1ns/100ps
module aosm_core #(
    parameter int FAULT_CYC = aosm_pkg::FAULT_STABLE_CYC,
    parameter int PWM_CYC = aosm_pkg::PWM_ON_CYC,
    parameter int DEB = aosm_pkg::DEB_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [3:0] i_select_pin,
    input wire logic i_pll_locked,
    input wire logic i_i2s_valid,
    input wire logic i_supply_reset,
    input wire aosm_pkg::aosm_fault_s i_fault,
    input wire logic i_overvolt_shutdown,
    input wire logic i_low_batt,
    input wire logic i_high_batt,
    input wire logic i_thermal_mute,
    input wire logic i_hardware_mute_input,
    input wire logic i_cmd_pwm_on,
    input wire logic i_cmd_play,
    input wire logic i_cmd_dc_diag,
    input wire logic i_cmd_prog_change,
    input wire logic [aosm_pkg::RAMP_SEL_W-1:0] i_ramp_sel,
    output aosm_pkg::aosm_state_e o_state,
    output logic [6:0] o_i2c_target_addr,
    output logic o_i2c_target_en,
    output logic o_legacy,
    output logic o_low_voltage,
    output logic o_out_phase,
    output logic o_supplies_on,
    output logic o_bias_mid,
    output logic o_load_defaults,
    output logic o_pwm_on,
    output logic o_play,
    output logic [aosm_pkg::RAMP_SEL_W-1:0] o_ramp_sel,
    output logic o_fault_reported,
    output logic o_i2s_enable
);

    ////////////////////////////////////////////////////////////////////////////////
    // Input conditioning.

    aosm_pkg::aosm_sel_s sel;
    logic [4:0] amute_meta_r;
    logic [4:0] amute_sync_r;
    logic [2:0] sys_meta_r;
    logic [2:0] sys_sync_r;

    aosm_sel_debounce #(.DEB(DEB)) u_sel (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_sel(i_select_pin),
        .o_sel(sel)
    );

    // Pin-level status inputs pass two flops; the mute pin sits high when floating.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            amute_meta_r <= 5'h00;
            amute_sync_r <= 5'h00;
            sys_meta_r <= 3'h0;
            sys_sync_r <= 3'h0;
        end else begin
            amute_meta_r <= {i_low_batt, i_high_batt, i_thermal_mute,
                             !i_hardware_mute_input, i_overvolt_shutdown}; // see R22
            amute_sync_r <= amute_meta_r;
            sys_meta_r <= {!i_pll_locked, !i_i2s_valid, i_supply_reset};
            sys_sync_r <= sys_meta_r;
        end
    end

    logic any_amute;
    logic ov_shutdown;
    logic sys_reset;
    logic diag_fault;
    logic trip_fault;
    assign any_amute = |amute_sync_r[4:1]; // see R17
    assign ov_shutdown = amute_sync_r[0];
    assign sys_reset = |sys_sync_r; // see R6
    assign diag_fault = i_fault.short_gnd | i_fault.short_vcc | i_fault.uvlo
                      | i_fault.thermal_sd; // see R8
    assign trip_fault = i_fault.overcurrent | i_fault.uvlo | i_fault.load_dump
                      | i_fault.thermal_sd; // see R12

    ////////////////////////////////////////////////////////////////////////////////
    // Timers.

    aosm_pkg::aosm_state_e state_r;
    aosm_pkg::aosm_state_e state_nxt;
    logic clean_done;
    logic fault_done;
    logic pwm_done;

    // Clean interval in diagnostic before leaving.
    aosm_timer #(.N(FAULT_CYC)) u_clean (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_run(state_r == aosm_pkg::AOSM_DIAG && !diag_fault),
        .o_done(clean_done)
    );

    // Fault must persist the same interval before being reported.
    aosm_timer #(.N(FAULT_CYC)) u_fault (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_run(state_r == aosm_pkg::AOSM_DIAG && diag_fault),
        .o_done(fault_done)
    );

    // PWM start-up interval after the PWM-on command.
    aosm_timer #(.N(PWM_CYC)) u_pwm (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_run(state_r == aosm_pkg::AOSM_MUTE || state_r == aosm_pkg::AOSM_PLAY
               || state_r == aosm_pkg::AOSM_DCDIAG),
        .o_done(pwm_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // State machine.

    logic prog_dirty_r;
    logic was_amuted_r;

    // Next state; amplifier reset conditions outrank everything, trips come next.
    always_comb begin
        state_nxt = state_r;
        if (!sel.valid || sys_reset) begin
            state_nxt = aosm_pkg::AOSM_STANDBY; // see R1 see R6 see R23
        end else if (state_r != aosm_pkg::AOSM_STANDBY && trip_fault) begin
            state_nxt = aosm_pkg::AOSM_DIAG; // see R12
        end else begin
            case (state_r)
                aosm_pkg::AOSM_STANDBY: state_nxt = aosm_pkg::AOSM_DIAG; // see R5 see R8
                aosm_pkg::AOSM_DIAG: begin
                    if (clean_done) begin
                        state_nxt = aosm_pkg::AOSM_IDLE; // see R9
                    end
                end
                aosm_pkg::AOSM_IDLE: begin
                    if (i_cmd_pwm_on || sel.legacy) begin
                        state_nxt = aosm_pkg::AOSM_MUTE; // see R14
                    end
                end
                aosm_pkg::AOSM_MUTE: begin
                    if (i_cmd_dc_diag) begin
                        state_nxt = aosm_pkg::AOSM_DCDIAG; // see R19
                    end else if (!any_amute && (i_cmd_play || sel.legacy)
                                 && !(was_amuted_r && prog_dirty_r)) begin
                        state_nxt = aosm_pkg::AOSM_PLAY; // see R15 see R18
                    end
                end
                aosm_pkg::AOSM_PLAY: begin
                    if (any_amute || !(i_cmd_play || sel.legacy)) begin
                        state_nxt = aosm_pkg::AOSM_MUTE; // see R15 see R17
                    end
                end
                aosm_pkg::AOSM_DCDIAG: begin
                    if (!i_cmd_dc_diag) begin
                        state_nxt = aosm_pkg::AOSM_MUTE;
                    end
                end
                default: state_nxt = aosm_pkg::AOSM_STANDBY;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= aosm_pkg::AOSM_STANDBY;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Remember an automatic mute and any host reprogramming during it.
    // A reprogram in the same cycle the mute lifts is lost; prog_dirty_r is still clear, so play resumes.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            was_amuted_r <= 1'b0;
            prog_dirty_r <= 1'b0;
        end else if (state_r == aosm_pkg::AOSM_PLAY && any_amute) begin
            was_amuted_r <= 1'b1;
            prog_dirty_r <= 1'b0;
        end else if (state_r == aosm_pkg::AOSM_MUTE && was_amuted_r) begin
            if (i_cmd_prog_change || !i_cmd_play) begin
                prog_dirty_r <= 1'b1; // see R18
            end
            if (!any_amute && !i_cmd_play) begin
                was_amuted_r <= 1'b0;
                prog_dirty_r <= 1'b0;
            end
        end else if (state_r != aosm_pkg::AOSM_MUTE) begin
            was_amuted_r <= 1'b0;
            prog_dirty_r <= 1'b0;
        end
    end

    // Sticky stable-fault report, cleared when the fault has gone.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_fault_reported <= 1'b0;
        end else if (fault_done) begin
            o_fault_reported <= 1'b1; // see R10
        end else if (state_r == aosm_pkg::AOSM_STANDBY || !diag_fault) begin
            o_fault_reported <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops.

    // Address and mode latch; target only, never drives a bus as controller.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_i2c_target_addr <= 7'h00;
            o_i2c_target_en <= 1'b0;
            o_legacy <= 1'b0;
            o_low_voltage <= 1'b0;
            o_out_phase <= 1'b0;
        end else begin
            o_i2c_target_addr <= sel.addr; // see R2 see R3
            o_i2c_target_en <= sel.valid && !sel.legacy; // see R7
            o_legacy <= sel.legacy; // see R4
            o_low_voltage <= sel.low_voltage;
            o_out_phase <= sel.out_phase;
        end
    end

    // Power, bias and PWM. Holding PWM until the start-up interval avoids pops.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_supplies_on <= 1'b0;
            o_bias_mid <= 1'b0;
            o_load_defaults <= 1'b1;
            o_pwm_on <= 1'b0;
            o_play <= 1'b0;
            o_ramp_sel <= '0;
            o_i2s_enable <= 1'b0;
        end else begin
            o_supplies_on <= state_nxt != aosm_pkg::AOSM_STANDBY; // see R5
            o_bias_mid <= state_nxt != aosm_pkg::AOSM_STANDBY;
            o_load_defaults <= state_nxt == aosm_pkg::AOSM_STANDBY;
            o_pwm_on <= pwm_done && state_nxt != aosm_pkg::AOSM_IDLE
                        && state_nxt != aosm_pkg::AOSM_DIAG
                        && state_nxt != aosm_pkg::AOSM_STANDBY; // see R11 see R13 see R14
            o_play <= state_nxt == aosm_pkg::AOSM_PLAY;
            o_ramp_sel <= i_ramp_sel; // see R16
            o_i2s_enable <= !ov_shutdown && state_nxt != aosm_pkg::AOSM_STANDBY; // see R20
        end
    end

    assign o_state = state_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_in_diag;
        state_r == aosm_pkg::AOSM_DIAG;
    endsequence

    chk_diag_no_pwm: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R11
        s_in_diag |-> ##1 !o_pwm_on)
        else $error("PWM on while diagnosing.");
    chk_idle_no_pwm: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R13
        state_r == aosm_pkg::AOSM_IDLE |-> !o_pwm_on)
        else $error("PWM on while idle.");
    chk_diag_exit_clean: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R9
        s_in_diag ##1 state_r == aosm_pkg::AOSM_IDLE |-> $past(clean_done))
        else $error("Left diagnostic without clean interval.");
    chk_standby_off: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R1
        state_r == aosm_pkg::AOSM_STANDBY |=> !o_supplies_on || state_r != aosm_pkg::AOSM_STANDBY)
        else $error("Supplies on in standby.");
    chk_trip_diag: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R12
        (trip_fault && sel.valid && !sys_reset && state_r != aosm_pkg::AOSM_STANDBY)
        |=> state_r == aosm_pkg::AOSM_DIAG)
        else $error("Trip did not force diagnostic.");
    chk_reset_standby: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R6
        sys_reset |=> state_r == aosm_pkg::AOSM_STANDBY)
        else $error("System reset did not reach standby.");
    chk_amute_mute: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R17
        (state_r == aosm_pkg::AOSM_PLAY && any_amute && !trip_fault && sel.valid && !sys_reset)
        |=> state_r == aosm_pkg::AOSM_MUTE)
        else $error("Auto mute ignored.");
    chk_dcdiag_from_mute: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R19
        state_r == aosm_pkg::AOSM_DCDIAG && $past(state_r) != aosm_pkg::AOSM_DCDIAG
        |-> $past(state_r) == aosm_pkg::AOSM_MUTE)
        else $error("DC diagnostic entered from wrong state.");
    chk_ov_i2s_off: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R20
        ov_shutdown |=> !o_i2s_enable)
        else $error("Audio input left on in overvoltage.");

endmodule

// ==== verilog/aosm_pkg.sv ====
// Package for the amplifier operating state machine: states, select decoding, timing.
// Assumes a single 25 MHz system clock shared by every module that uses it.
package aosm_pkg;

    // Operating states of the amplifier.
    typedef enum logic [2:0] {
        AOSM_STANDBY,
        AOSM_DIAG,
        AOSM_IDLE,
        AOSM_MUTE,
        AOSM_PLAY,
        AOSM_DCDIAG
    } aosm_state_e;

    // Decoded select-pin combination.
    typedef struct packed {
        logic       valid;
        logic       legacy;
        logic [6:0] addr;
        logic       low_voltage;
        logic       out_phase;
    } aosm_sel_s;

    // Fault inputs checked in the diagnostic state or forcing a return to it.
    typedef struct packed {
        logic short_gnd;
        logic short_vcc;
        logic uvlo;
        logic thermal_sd;
        logic overcurrent;
        logic load_dump;
    } aosm_fault_s;

    // Automatic mute sources.
    typedef struct packed {
        logic low_batt;
        logic high_batt;
        logic thermal;
        logic hw_pin;
    } aosm_amute_s;

    localparam int CLK_HZ = 25_000_000;
    localparam int FAULT_STABLE_MS = 90;
    localparam int FAULT_STABLE_CYC = (CLK_HZ / 1000) * FAULT_STABLE_MS;
    localparam int PWM_ON_US = 1000;
    localparam int PWM_ON_CYC = (CLK_HZ / 1_000_000) * PWM_ON_US;
    localparam int DEB_CYC = 16;
    localparam logic [6:0] ADDR_BASE = 7'h70;
    localparam int RAMP_SEL_W = 2;

endpackage

// ==== verilog/aosm_sel_debounce.sv ====
// Select-pin synchroniser and debouncer with pattern decoding.
// Assumes the select pins are asynchronous to i_mclk.
`timescale 1ns/100ps
module aosm_sel_debounce #(
    parameter int DEB = aosm_pkg::DEB_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [3:0] i_sel,
    output aosm_pkg::aosm_sel_s o_sel
);

    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic [3:0] last_r;
    logic [15:0] cnt_r;
    logic [3:0] stable_r;

    // Decode pins in order pin1..pin4 as bits 3..0.
    function automatic aosm_pkg::aosm_sel_s decode(input logic [3:0] p);
        aosm_pkg::aosm_sel_s s;
        s = '0;
        case (p)
            4'b0100: begin s.valid = 1'b1; s.addr = aosm_pkg::ADDR_BASE + 7'h0; end // see R2
            4'b1100: begin s.valid = 1'b1; s.addr = aosm_pkg::ADDR_BASE + 7'h1; end
            4'b0010: begin s.valid = 1'b1; s.addr = aosm_pkg::ADDR_BASE + 7'h2; end
            4'b0110: begin s.valid = 1'b1; s.addr = aosm_pkg::ADDR_BASE + 7'h3; end
            4'b0101: begin s.valid = 1'b1; s.addr = aosm_pkg::ADDR_BASE + 7'h4; end // see R3
            4'b1101: begin s.valid = 1'b1; s.addr = aosm_pkg::ADDR_BASE + 7'h5; end
            4'b0011: begin s.valid = 1'b1; s.addr = aosm_pkg::ADDR_BASE + 7'h6; end
            4'b0111: begin s.valid = 1'b1; s.addr = aosm_pkg::ADDR_BASE + 7'h7; end
            4'b1110: begin s.valid = 1'b1; s.legacy = 1'b1; s.low_voltage = 1'b1; end // see R4
            4'b1111: begin
                s.valid = 1'b1;
                s.legacy = 1'b1;
                s.low_voltage = 1'b1;
                s.out_phase = 1'b1;
            end
            4'b1000: begin s.valid = 1'b1; s.legacy = 1'b1; end
            4'b1001: begin s.valid = 1'b1; s.legacy = 1'b1; s.out_phase = 1'b1; end
            default: s = '0; // Standby and unlisted patterns keep the amp off, see R1 see R23.
        endcase
        return s;
    endfunction

    // Two-stage synchroniser.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_r <= 4'h0;
            sync_r <= 4'h0;
        end else begin
            meta_r <= i_sel;
            sync_r <= meta_r;
        end
    end

    // Commit a pattern only after it stays unchanged for DEB cycles, see R24.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            last_r <= 4'h0;
            cnt_r <= 16'h0000;
            stable_r <= 4'h0;
        end else if (sync_r != last_r) begin
            last_r <= sync_r;
            cnt_r <= 16'h0000;
        end else if (cnt_r >= 16'(DEB - 1)) begin
            stable_r <= last_r;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    assign o_sel = decode(stable_r);

    chk_deb_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R24
        $changed(stable_r) |-> $past(sync_r) == stable_r)
        else $error("Select pattern committed without being stable.");

endmodule

// ==== verilog/aosm_timer.sv ====
// Up-counting timer that reports when a continuously held condition has lasted N cycles.
// Assumes one clock domain; run low restarts the count.
`timescale 1ns/100ps
module aosm_timer #(
    parameter int N = 16,
    parameter int W = 32
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_run,
    output logic o_done
);

    logic [W-1:0] cnt_r;

    // Count while run holds; a drop restarts the interval from zero.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= '0;
        end else if (!i_run) begin
            cnt_r <= '0;
        end else if (cnt_r < W'(N)) begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    assign o_done = i_run && (cnt_r >= W'(N));

endmodule
